// ### src/tvps_top.sv
`timescale 1ns/1ps
`include "tvps_defines.svh"

module tvps_top #(
  parameter int unsigned ACK_CYC = `TVPS_ACK_CYC,
  parameter int unsigned RDDLY_CYC = `TVPS_RDDLY_CYC,
  parameter int unsigned NVRD_CYC = `TVPS_NVRD_CYC,
  parameter int unsigned FORCE_CYC = `TVPS_FORCE_CYC,
  parameter int unsigned MODIFY_CYC = `TVPS_MODIFY_CYC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe,
  input wire logic serial_enable_line_n_i,
  output logic serial_enable_line_n_o,
  output logic serial_enable_line_n_oe,
  input wire logic serial_clock_line_n,
  input wire logic divider_in,
  output logic prescaler_ratio,
  output logic lock_lost_out_n,
  output logic phase_detector_out_o,
  output logic phase_detector_out_oe,
  output logic [3:0] band_drive_bits,
  output logic [35:0] converter_levels
);

  tvps_pkg::tvps_top_st_t q, d;
  logic [15:0] nv_rdata;
  logic nv_vld;
  logic nv_done;

  // bit order on the wire is lsb first, so fields arrive reversed
  function automatic logic [7:0] rev8(input logic [7:0] v);
    rev8 = {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
  endfunction : rev8

  // readback value of one register, zero-extended
  function automatic logic [7:0] read_mux(input tvps_pkg::tvps_top_st_t s, input logic [3:0] a, input logic md);
    read_mux = 8'h00;
    if (a <= `TVPS_A_CONV_LAST) begin
      read_mux = {2'h0, s.conv[a[2:0]]};
    end else begin
      unique case (a)
        `TVPS_A_CNT_UP: read_mux = {1'h0, s.cnt_up};
        `TVPS_A_CNT_LO: read_mux = s.cnt_lo;
        `TVPS_A_BAND: read_mux = {1'h0, s.band};
        `TVPS_A_NV_ADDR: read_mux = {3'h0, s.nv_addr};
        `TVPS_A_NV_HI: read_mux = s.nv_hi;
        `TVPS_A_NV_LO: read_mux = s.nv_lo;
        `TVPS_A_STATUS: read_mux = {6'h00, s.rst_st, md};
        default: read_mux = 8'h00;
      endcase
    end
  endfunction : read_mux

  logic se_rise, se_fall, sc_rise, pdi_rise, word_ok, ref_tick;
  logic [3:0] w_addr;
  logic [7:0] w_data;
  logic w_load;

  // decode of the captured word and pin edges
  always_comb begin
    se_rise = q.s2[1] && !q.s3[1];
    se_fall = !q.s2[1] && q.s3[1];
    sc_rise = q.s2[2] && !q.s3[2];
    pdi_rise = q.s2[3] && !q.s3[3];
    w_load = q.sh[12];
    w_addr = {q.sh[8], q.sh[9], q.sh[10], q.sh[11]};
    w_data = rev8(q.sh[7:0]);
    word_ok = (q.nbits == `TVPS_WORD_LEN) && !q.sh[14] && (^q.sh);
    ref_tick = (q.ref_cnt == `TVPS_REF_LAST);
  end

  // next-state logic for the whole block
  always_comb begin
    logic hi, lo, fz, done_cmp, cnt_load;
    hi = 1'b0;
    lo = 1'b0;
    fz = 1'b0;
    done_cmp = 1'b0;
    cnt_load = 1'b0;
    d = q;
    d.s1 = {divider_in, serial_clock_line_n, serial_enable_line_n_i, serial_data_line_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.nv_rd_go = 1'b0;
    d.nv_st_go = 1'b0;
    d.nv_abort = 1'b0;
    d.div_tick = 1'b0;
    d.tcnt = q.tcnt + 16'h0001;

    // serial framing, acknowledge and readback
    unique case (q.state)
      tvps_pkg::ST_IDLE: begin
        if (se_fall) begin
          d.state = tvps_pkg::ST_SHIFT;
          d.nbits = 5'h00;
          d.sh = 15'h0000;
        end
      end
      tvps_pkg::ST_SHIFT: begin
        if (sc_rise) begin
          d.sh = {q.sh[13:0], q.s2[0]};
          if (q.nbits != 5'h1F) begin
            d.nbits = q.nbits + 5'h01;
          end
        end
        if (se_rise) begin
          d.tcnt = 16'h0000;
          if (!word_ok) begin
            d.state = tvps_pkg::ST_IDLE;
          end else if (w_load) begin
            d.state = tvps_pkg::ST_ACK;
            d.se_oe = 1'b1;
            if (w_addr <= `TVPS_A_CONV_LAST) begin
              d.conv[w_addr[2:0]] = w_data[5:0];
            end else begin
              unique case (w_addr)
                `TVPS_A_CNT_UP: d.cnt_up = w_data[6:0];
                `TVPS_A_CNT_LO: begin
                  d.cnt_lo = w_data;
                  d.prog = {q.cnt_up, w_data[7:4]};
                  d.swal = w_data[3:0];
                  d.pc = {q.cnt_up, w_data[7:4]};
                  d.sc = w_data[3:0];
                  d.swal_ph = 1'b1;
                  cnt_load = 1'b1;
                end
                `TVPS_A_BAND: begin
                  d.band = w_data[6:0];
                  d.frc_cnt = 20'h00000;
                end
                `TVPS_A_NV_ADDR: begin
                  d.nv_addr = w_data[4:0];
                  d.nv_st_go = q.dirty;
                  d.nv_rd_go = !q.dirty;
                  d.dirty = 1'b0;
                end
                `TVPS_A_NV_HI: begin
                  d.nv_hi = w_data;
                  d.dirty = 1'b1;
                end
                `TVPS_A_NV_LO: begin
                  d.nv_lo = w_data;
                  d.dirty = 1'b1;
                end
                `TVPS_A_STATUS: d.nv_abort = w_data[`TVPS_F_MOD];
                default: d.cnt_up = q.cnt_up;
              endcase
            end
          end else begin
            d.state = tvps_pkg::ST_RDWAIT;
            d.se_oe = 1'b1;
            d.rd_sh = read_mux(q, w_addr, nv_done);
            if (w_addr == `TVPS_A_STATUS) begin
              d.rst_st = 1'b1;
            end
          end
        end
      end
      tvps_pkg::ST_ACK: begin
        if (q.tcnt == 16'(ACK_CYC - 1)) begin
          d.state = tvps_pkg::ST_IDLE;
          d.se_oe = 1'b0;
        end
      end
      tvps_pkg::ST_RDWAIT: begin
        if (q.tcnt == 16'(RDDLY_CYC - 1)) begin
          d.state = tvps_pkg::ST_RDOUT;
          d.se_oe = 1'b0;
          d.sd_oe = 1'b1;
          d.sd_o = q.rd_sh[0];
          d.rd_n = 4'h0;
        end
      end
      tvps_pkg::ST_RDOUT: begin
        if (sc_rise) begin
          if (q.rd_n == `TVPS_RD_LAST) begin
            d.state = tvps_pkg::ST_IDLE;
            d.sd_oe = 1'b0;
          end else begin
            d.rd_sh = {1'b0, q.rd_sh[7:1]};
            d.sd_o = q.rd_sh[1];
            d.rd_n = q.rd_n + 4'h1;
          end
        end
      end
    endcase

    // memory word arrives in the two data registers
    if (nv_vld) begin
      d.nv_hi = nv_rdata[15:8];
      d.nv_lo = nv_rdata[7:0];
    end

    // swallow phase divides by 16, program phase by 15; a count load wins over a divider edge
    if (pdi_rise && !cnt_load) begin
      if (q.swal_ph) begin
        if (q.sc == 4'h0) begin
          d.swal_ph = 1'b0;
        end else begin
          d.sc = q.sc - 4'h1;
        end
      end else if (q.pc == 11'h000) begin
        d.div_tick = 1'b1;
        d.pc = q.prog;
        d.sc = q.swal;
        d.swal_ph = 1'b1;
      end else begin
        d.pc = q.pc - 11'h001;
      end
    end
    d.pcm = !q.swal_ph;

    // reference divider and three-state phase comparator
    d.ref_cnt = q.ref_cnt + 12'h001;
    done_cmp = (q.up || ref_tick) && (q.dn || q.div_tick);
    if (done_cmp) begin
      d.up = 1'b0;
      d.dn = 1'b0;
      d.lost = (q.ph_cnt > 10'(`TVPS_PHERR_CYC));
      d.ph_cnt = 10'h000;
    end else begin
      d.up = q.up || ref_tick;
      d.dn = q.dn || q.div_tick;
      if ((q.up || q.dn) && q.ph_cnt != 10'h3FF) begin
        d.ph_cnt = q.ph_cnt + 10'h001;
      end
      if (q.ph_cnt > 10'(`TVPS_PHERR_CYC)) begin
        d.lost = 1'b1;
      end
    end

    // overrides of the phase output; forced levels time out
    hi = q.band[`TVPS_F_HIGH];
    lo = q.band[`TVPS_F_LOW];
    fz = q.band[`TVPS_F_FLOAT];
    if ((hi || lo) && d.frc_cnt == q.frc_cnt) begin
      d.frc_cnt = q.frc_cnt + 20'h00001;
      if (q.frc_cnt == 20'(FORCE_CYC - 1)) begin
        d.band[`TVPS_F_HIGH] = 1'b0;
        d.band[`TVPS_F_LOW] = 1'b0;
        d.frc_cnt = 20'h00000;
      end
    end
    if (hi ^ lo) begin
      d.pd_oe = 1'b1;
      d.pd_o = hi;
    end else if (fz) begin
      d.pd_oe = 1'b0;
      d.pd_o = 1'b0;
    end else begin
      d.pd_oe = q.up || q.dn;
      d.pd_o = q.up;
    end
    d.lock_n = !(!q.rst_st || (q.lost && !(fz && !(hi ^ lo))));
  end

  // state register; reset floats the phase output
  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
      q.state <= tvps_pkg::ST_IDLE;
      q.band <= `TVPS_BAND_RST;
      q.swal_ph <= 1'b1;
      // pin history starts at idle levels so no false edge follows reset
      q.s1 <= 4'h7;
      q.s2 <= 4'h7;
      q.s3 <= 4'h7;
    end else begin
      q <= d;
    end
  end

  tvps_nvm #(
    .READY_CYC(NVRD_CYC),
    .MODIFY_CYC(MODIFY_CYC)
  ) u_nvm (
    .clock(clock),
    .srst(srst),
    .rd_go(q.nv_rd_go),
    .st_go(q.nv_st_go),
    .abort(q.nv_abort),
    .addr(q.nv_addr),
    .wdata({q.nv_hi, q.nv_lo}),
    .rdata(nv_rdata),
    .rdata_vld(nv_vld),
    .mod_done(nv_done)
  );

  // pins straight from flops, except the enable output level, which is tied low
  assign serial_data_line_o = q.sd_o;
  assign serial_data_line_oe = q.sd_oe;
  assign serial_enable_line_n_o = 1'b0;
  assign serial_enable_line_n_oe = q.se_oe;
  assign prescaler_ratio = q.pcm;
  assign lock_lost_out_n = q.lock_n;
  assign phase_detector_out_o = q.pd_o;
  assign phase_detector_out_oe = q.pd_oe;
  assign band_drive_bits = q.band[3:0];
  assign converter_levels = q.conv;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence good_load_s;
    q.state == tvps_pkg::ST_SHIFT && se_rise && word_ok && w_load;
  endsequence
  sequence good_read_s;
    q.state == tvps_pkg::ST_SHIFT && se_rise && word_ok && !w_load;
  endsequence

  ack_hold_a: assert property ($rose(serial_enable_line_n_oe) |-> serial_enable_line_n_oe [*8])
    else $error("acknowledge too short");
  bad_word_a: assert property (q.state == tvps_pkg::ST_SHIFT && se_rise && !word_ok
    |=> q.state == tvps_pkg::ST_IDLE && !serial_enable_line_n_oe && $stable(q.conv) && $stable(q.band))
    else $error("malformed word was taken");
  conv_load_a: assert property (good_load_s ##0 (w_addr == 4'h0)
    |=> converter_levels[5:0] == $past(w_data[5:0])) else $error("converter level not loaded");
  read_pull_a: assert property (good_read_s |=> serial_enable_line_n_oe && !serial_data_line_oe)
    else $error("read word not answered at once");
  pll_xfer_a: assert property (good_load_s ##0 (w_addr == `TVPS_A_CNT_LO)
    |=> q.prog == {$past(q.cnt_up), $past(w_data[7:4])} && q.swal_ph)
    else $error("count transfer wrong");
  float_out_a: assert property (q.band[6:4] == 3'h1 |=> !phase_detector_out_oe)
    else $error("phase output driven while floating");
  force_low_a: assert property (q.band[6:4] == 3'h2 || q.band[6:4] == 3'h3
    |=> phase_detector_out_oe && !phase_detector_out_o) else $error("force low not driven");
  force_high_a: assert property (q.band[6:5] == 2'h2
    |=> phase_detector_out_oe && phase_detector_out_o) else $error("force high not driven");
  float_lock_a: assert property (q.band[6:4] == 3'h1 && q.rst_st |=> lock_lost_out_n)
    else $error("lock loss shown while floating");
  rst_read_a: assert property (good_read_s ##0 (w_addr == `TVPS_A_STATUS)
    |=> q.rst_st ##1 lock_lost_out_n || $past(q.lost)) else $error("reset status not restored by read");
  ratio_ctl_a: assert property (q.swal_ph |=> !prescaler_ratio)
    else $error("prescaler ratio wrong in swallow phase");
  ref_period_a: assert property (ref_tick |=> !ref_tick [*8])
    else $error("reference tick repeats early");

endmodule : tvps_top

// ### src/tvps_defines.svh
`ifndef TVPS_DEFINES_SVH
`define TVPS_DEFINES_SVH

// timing base
`define TVPS_CLK_MHZ 200
`define TVPS_ACK_US 22
`define TVPS_ACK_CYC (`TVPS_ACK_US * `TVPS_CLK_MHZ)
`define TVPS_RDDLY_US 24
`define TVPS_RDDLY_CYC (`TVPS_RDDLY_US * `TVPS_CLK_MHZ)
`define TVPS_NVRD_US 200
`define TVPS_NVRD_CYC (`TVPS_NVRD_US * `TVPS_CLK_MHZ)
`define TVPS_FORCE_US 1000
`define TVPS_FORCE_CYC (`TVPS_FORCE_US * `TVPS_CLK_MHZ)
`define TVPS_MODIFY_US 2000
`define TVPS_MODIFY_CYC (`TVPS_MODIFY_US * `TVPS_CLK_MHZ)
`define TVPS_PHERR_NS 2000
`define TVPS_PHERR_CYC ((`TVPS_PHERR_NS * `TVPS_CLK_MHZ) / 1000)
`define TVPS_REF_LAST 12'hFFF
`define TVPS_WORD_LEN 5'h0F
`define TVPS_RD_LAST 4'h7

// register addresses
`define TVPS_A_CONV_LAST 4'h5
`define TVPS_A_CNT_UP 4'h6
`define TVPS_A_CNT_LO 4'h7
`define TVPS_A_BAND 4'h8
`define TVPS_A_NV_ADDR 4'h9
`define TVPS_A_NV_HI 4'hA
`define TVPS_A_NV_LO 4'hB
`define TVPS_A_STATUS 4'hC

// field positions
`define TVPS_F_FLOAT 4
`define TVPS_F_LOW 5
`define TVPS_F_HIGH 6
`define TVPS_F_MOD 0
`define TVPS_F_RST 1

// reset values
`define TVPS_BAND_RST 7'h10

`endif

// ### src/tvps_pkg.sv
package tvps_pkg;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_SHIFT  = 5'h02,
    ST_ACK    = 5'h04,
    ST_RDWAIT = 5'h08,
    ST_RDOUT  = 5'h10
  } tvps_rx_state_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    tvps_rx_state_t state;
    logic [14:0] sh;
    logic [4:0] nbits;
    logic [15:0] tcnt;
    logic [7:0] rd_sh;
    logic [3:0] rd_n;
    logic [5:0][5:0] conv;
    logic [6:0] cnt_up;
    logic [7:0] cnt_lo;
    logic [6:0] band;
    logic [4:0] nv_addr;
    logic [7:0] nv_hi;
    logic [7:0] nv_lo;
    logic dirty;
    logic rst_st;
    logic nv_rd_go;
    logic nv_st_go;
    logic nv_abort;
    logic [10:0] prog;
    logic [3:0] swal;
    logic [10:0] pc;
    logic [3:0] sc;
    logic swal_ph;
    logic div_tick;
    logic [11:0] ref_cnt;
    logic up;
    logic dn;
    logic [9:0] ph_cnt;
    logic lost;
    logic [19:0] frc_cnt;
    logic sd_o;
    logic sd_oe;
    logic se_oe;
    logic lock_n;
    logic pd_o;
    logic pd_oe;
    logic pcm;
  } tvps_top_st_t;

  typedef struct packed {
    logic [31:0][15:0] mem;
    logic busy_rd;
    logic busy_st;
    logic [19:0] cnt;
    logic [4:0] a;
    logic [15:0] w;
    logic [15:0] rdata;
    logic vld;
    logic done;
  } tvps_nvm_st_t;

endpackage : tvps_pkg

// ### src/tvps_nvm.sv
`timescale 1ns/1ps
`include "tvps_defines.svh"

module tvps_nvm #(
  parameter int unsigned READY_CYC = `TVPS_NVRD_CYC,
  parameter int unsigned MODIFY_CYC = `TVPS_MODIFY_CYC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic rd_go,
  input wire logic st_go,
  input wire logic abort,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata,
  output logic rdata_vld,
  output logic mod_done
);

  tvps_pkg::tvps_nvm_st_t q, d;

  // word read after the ready delay, store after the modify time
  always_comb begin
    d = q;
    d.vld = 1'b0;
    if (q.busy_rd || q.busy_st) begin
      d.cnt = q.cnt + 20'h00001;
    end
    if (q.busy_rd && q.cnt == 20'(READY_CYC - 1)) begin
      d.busy_rd = 1'b0;
      d.rdata = q.mem[q.a];
      d.vld = 1'b1;
    end
    if (q.busy_st && q.cnt == 20'(MODIFY_CYC - 1)) begin
      d.busy_st = 1'b0;
      d.mem[q.a] = q.w;
      d.done = 1'b1;
    end
    if (st_go) begin
      d.busy_st = 1'b1;
      d.busy_rd = 1'b0;
      d.cnt = 20'h00000;
      d.a = addr;
      d.w = wdata;
      d.done = 1'b0;
    end else if (rd_go) begin
      d.busy_rd = 1'b1;
      d.busy_st = 1'b0;
      d.cnt = 20'h00000;
      d.a = addr;
    end
    // abort ends the store and marks the modify over
    if (abort && !st_go) begin
      d.busy_st = 1'b0;
      d.done = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
      q.done <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign rdata_vld = q.vld;
  assign mod_done = q.done;

  store_busy_a: assert property (@(posedge clock) disable iff (srst)
    st_go |=> !mod_done ##0 q.busy_st) else $error("store start did not clear done");

endmodule : tvps_nvm

// ### verif/tvps_host.sv
`timescale 1ns/1ps

// host side of the three-wire bus: frames words, times the answer, fetches read data
module tvps_host #(
  parameter int PH = 6
) (
  input wire logic clock,
  input wire logic dev_data,
  input wire logic dev_data_oe,
  input wire logic dev_en_n,
  input wire logic dev_en_oe,
  output logic data_line,
  output logic en_line_n,
  output logic sclk_n,
  output logic [7:0] rd_data,
  output logic rd_tgl,
  output logic [15:0] ack_len,
  output logic ack_tgl
);
  logic h_data;
  logic h_data_oe;
  logic h_en_n;

  // wire levels: both lines pulled up, a released data line floats high
  assign data_line = dev_data_oe ? dev_data : (h_data_oe ? h_data : 1'b1);
  assign en_line_n = h_en_n & ~(dev_en_oe & ~dev_en_n);

  // idle bus, serial clock stands high outside frames
  initial begin
    h_data = 1'b0;
    h_data_oe = 1'b0;
    h_en_n = 1'b1;
    sclk_n = 1'b1;
    rd_data = 8'h00;
    rd_tgl = 1'b0;
    ack_len = 16'h0000;
    ack_tgl = 1'b0;
  end

  // word with select low and an odd count of ones
  function automatic logic [14:0] mk(input logic rw, input logic [3:0] a, input logic [7:0] d);
    logic [14:0] w;
    w = {d, a, rw, 2'b00};
    w[1] = ~^w;
    return w;
  endfunction : mk

  // one clock pulse: low half, then the rising edge that latches
  task automatic pulse();
    sclk_n = 1'b0;
    repeat (PH) @(negedge clock);
    sclk_n = 1'b1;
    repeat (PH) @(negedge clock);
  endtask : pulse

  // send n bits of w, time the enable pull-down, fetch eight bits on reads
  task automatic xfer(input logic [14:0] w, input int n, input logic rd);
    int k;
    logic [7:0] r;
    @(negedge clock);
    h_en_n = 1'b0;
    h_data_oe = 1'b1;
    repeat (PH) @(negedge clock);
    for (k = 0; k < n; k++) begin
      h_data = w[k];
      pulse();
    end
    h_en_n = 1'b1;
    h_data_oe = 1'b0;
    for (k = 0; k < 20 && dev_en_oe !== 1'b1; k++) @(negedge clock);
    ack_len = 16'h0000;
    while (dev_en_oe === 1'b1 && ack_len < 16'hFFFF) begin
      ack_len++;
      @(negedge clock);
    end
    if (rd && ack_len != 16'h0000) begin
      r[0] = data_line;
      for (k = 1; k < 8; k++) begin
        pulse();
        r[k] = data_line;
      end
      pulse();
      rd_data = r;
      rd_tgl = ~rd_tgl;
    end
    ack_tgl = ~ack_tgl;
  endtask : xfer
endmodule : tvps_host

// ### verif/tv_pll_serial_control_bench.sv
`timescale 1ns/1ps

// bench: host model drives the bus, answers are checked against queued notes
module tv_pll_serial_control_bench;
  localparam int ACK = 16;
  localparam int RDD = 20;
  logic clock;
  logic srst;
  logic divider_in;
  logic sd, sd_o, sd_oe, se_n, se_o, se_oe, sc_n, pcm, lock_n, pd_o, pd_oe;
  logic [3:0] band;
  logic [35:0] conv;
  logic [42:0] pins;
  logic [7:0] rd_data;
  logic rd_tgl, ack_tgl, rd_seen, ack_seen;
  logic [15:0] ack_len, x;
  logic [15:0] ack_q[$];
  logic [15:0] rd_q[$];
  logic [35:0] lv;
  logic [14:0] w;
  int fail_count, checks, seed, k, n;

  assign pins = {lock_n, pd_oe, pd_o, band, conv};

  tvps_top #(.ACK_CYC(ACK), .RDDLY_CYC(RDD), .NVRD_CYC(20), .FORCE_CYC(40), .MODIFY_CYC(400)) dut_u (
    .clock(clock), .srst(srst), .serial_data_line_i(sd), .serial_data_line_o(sd_o),
    .serial_data_line_oe(sd_oe), .serial_enable_line_n_i(se_n), .serial_enable_line_n_o(se_o),
    .serial_enable_line_n_oe(se_oe), .serial_clock_line_n(sc_n), .divider_in(divider_in),
    .prescaler_ratio(pcm), .lock_lost_out_n(lock_n), .phase_detector_out_o(pd_o),
    .phase_detector_out_oe(pd_oe), .band_drive_bits(band), .converter_levels(conv));

  tvps_host host_u (
    .clock(clock), .dev_data(sd_o), .dev_data_oe(sd_oe), .dev_en_n(se_o), .dev_en_oe(se_oe),
    .data_line(sd), .en_line_n(se_n), .sclk_n(sc_n), .rd_data(rd_data), .rd_tgl(rd_tgl),
    .ack_len(ack_len), .ack_tgl(ack_tgl));

  // clock generator
  always #2.5 clock = ~clock;

  task automatic report_and_stop();
    if (ack_q.size() != 0 || rd_q.size() != 0) bad("answers still awaited");
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic bad(input string m);
    fail_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : bad

  task automatic cmp_ack(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) bad($sformatf("enable pull-down %0d cycles, expected %0d", got, exp));
  endtask : cmp_ack

  task automatic cmp_rd(input logic [7:0] got, input logic [15:0] em);
    checks++;
    if ((got & em[15:8]) !== em[7:0]) bad($sformatf("read %h, expected %h", got, em[7:0]));
  endtask : cmp_rd

  task automatic cmp_pin(input logic [42:0] exp, input logic [42:0] m);
    checks++;
    if ((pins & m) !== exp) bad($sformatf("pins %h, expected %h", pins & m, exp));
  endtask : cmp_pin

  task automatic cmp_cnt(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) bad($sformatf("divider rises %0d, expected %0d", got, exp));
  endtask : cmp_cnt

  // one prescaler output period: four cycles high, four low
  task automatic div_pulse();
    divider_in = 1'b1;
    repeat (4) @(negedge clock);
    divider_in = 1'b0;
    repeat (4) @(negedge clock);
  endtask : div_pulse

  task automatic ld(input logic [3:0] a, input logic [7:0] d);
    ack_q.push_back(16'(ACK));
    host_u.xfer(host_u.mk(1'b1, a, d), 15, 1'b0);
  endtask : ld

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    ack_q.push_back(16'(RDD));
    rd_q.push_back({m, e});
    host_u.xfer(host_u.mk(1'b0, a, 8'h00), 15, 1'b1);
  endtask : rd

  // watcher: each answer takes the oldest note off its queue
  always @(posedge clock) begin
    if (ack_tgl !== ack_seen) begin
      ack_seen = ack_tgl;
      if (ack_q.size() == 0) bad("unexpected answer");
      else cmp_ack(ack_len, ack_q.pop_front());
    end
    if (rd_tgl !== rd_seen) begin
      rd_seen = rd_tgl;
      if (rd_q.size() == 0) bad("unexpected read data");
      else cmp_rd(rd_data, rd_q.pop_front());
    end
  end

  // watchdog
  initial begin
    repeat (60000) @(negedge clock);
    bad("watchdog expired");
    report_and_stop();
  end

  // main sequence
  initial begin
    clock = 1'b0;
    srst = 1'b1;
    divider_in = 1'b0;
    seed = 69884;
    fail_count = 0;
    checks = 0;
    ack_seen = 1'b0;
    rd_seen = 1'b0;
    repeat (8) @(negedge clock);
    srst = 1'b0;
    repeat (4) @(negedge clock);
    cmp_pin(43'h0, 43'h6FFFFFFFFFF);
    rd(4'hC, 8'h00, 8'h02);
    rd(4'hC, 8'h02, 8'h02);
    repeat (5000) @(negedge clock);
    cmp_pin({1'b1, 42'h0}, {1'b1, 42'h0});
    for (k = 0; k < 6; k++) begin
      x = 16'($random(seed));
      lv[6*k +: 6] = x[5:0];
      ld(4'(k), {2'b00, x[5:0]});
    end
    cmp_pin({7'h00, lv}, {7'h00, 36'hFFFFFFFFF});
    for (k = 0; k < 6; k++) rd(4'(k), {2'b00, lv[6*k +: 6]}, 8'hFF);
    ld(4'hD, 8'hFF);
    rd(4'hD, 8'h00, 8'hFF);
    // parity flipped, select set, one bit short
    w = host_u.mk(1'b1, 4'h0, {2'b00, ~lv[5:0]});
    for (k = 0; k < 3; k++) begin
      ack_q.push_back(16'h0000);
      host_u.xfer(w ^ (k == 0 ? 15'h0002 : k == 1 ? 15'h0003 : 15'h0000), k == 2 ? 14 : 15, 1'b0);
    end
    cmp_pin({7'h00, lv}, {7'h00, 36'hFFFFFFFFF});
    x = 16'($random(seed));
    ld(4'h6, {1'b0, x[6:0]});
    ld(4'h7, x[15:8]);
    ld(4'h8, 8'h05);
    cmp_pin({1'b0, 2'b10, 4'h5, 36'h0}, {1'b0, 2'b10, 4'hF, 36'h0});
    for (k = 0; k < 10000 && lock_n !== 1'b0; k++) @(negedge clock);
    cmp_pin(43'h0, {1'b1, 42'h0});
    ld(4'h8, 8'h15);
    repeat (8) @(negedge clock);
    cmp_pin({1'b1, 42'h0}, {2'b11, 41'h0});
    for (k = 5; k < 7; k++) begin
      ld(4'h8, 8'h05 | (8'h01 << k));
      cmp_pin({2'b01, k == 6, 40'h0}, {3'b011, 40'h0});
      repeat (60) @(negedge clock);
      rd(4'h8, 8'h05, 8'h7F);
    end
    // small counts, then rises counted in the swallow phase and in the program phase
    x = 16'($random(seed));
    ld(4'h6, {5'h00, x[10:8]});
    ld(4'h7, x[7:0]);
    for (n = 0; n < 300 && pcm === 1'b0; n++) div_pulse();
    cmp_cnt(16'(n), {12'h000, x[3:0]} + 16'h0001);
    for (n = 0; n < 300 && pcm === 1'b1; n++) div_pulse();
    cmp_cnt(16'(n), {9'h000, x[10:4]} + 16'h0001);
    x = 16'($random(seed));
    ld(4'hA, x[15:8]);
    ld(4'hB, x[7:0]);
    ld(4'h9, 8'h03);
    rd(4'hC, 8'h02, 8'h03);
    repeat (450) @(negedge clock);
    rd(4'hC, 8'h03, 8'h03);
    ld(4'hA, ~x[15:8]);
    ld(4'hB, ~x[7:0]);
    ld(4'h9, 8'h11);
    ld(4'hC, 8'h01);
    rd(4'hC, 8'h03, 8'h03);
    ld(4'h9, 8'h03);
    repeat (40) @(negedge clock);
    rd(4'hA, x[15:8], 8'hFF);
    rd(4'hB, x[7:0], 8'hFF);
    // second reset in mid-run: words go unanswered
    srst = 1'b1;
    ack_q.push_back(16'h0000);
    host_u.xfer(host_u.mk(1'b1, 4'h0, 8'h00), 15, 1'b0);
    srst = 1'b0;
    repeat (4) @(negedge clock);
    cmp_pin(43'h0, 43'h6FFFFFFFFFF);
    repeat (4) @(negedge clock);
    report_and_stop();
  end
endmodule : tv_pll_serial_control_bench
